// ### core/nibexe_core.sv
/*
 Fetch, decode and execute for port reads, increments and direct and
 conditional jumps of a 4-bit core. Assumes program memory answers in the
 same cycle the program counter is shown, and data memory likewise
 in the cycle of its read strobe. Other opcodes are stepped past as
 one-byte no-ops. Carry is only read here; nothing in this block writes it.
*/
// Notes on behaviour
// - port-read opcodes copy chosen port into accumulator
// - accumulator increment keeps carry unchanged
// - low pair memory nibble incremented, carry kept
// - high pair memory nibble incremented, carry kept
// - accumulator bit test jumps when bit set
// - jump on carry when carry is one
// - jump on no carry when carry zero
// - taken conditional jump keeps counter bit eleven
// - untaken conditional jump advances counter by two
// - direct jump loads all twelve counter bits
`timescale 1ns/1ns
`include "nibexe_defs.svh"
module nibexe_core (
    input  wire                           core_clk,
    input  wire                           rst,
    output logic [11:0]                   prog_addr,
    input  wire  [7:0]                    prog_data,
    output nibexe_pkg::nibexe_mem_req_type mem_req,
    input  wire  nibexe_pkg::nibexe_nib_type mem_rdata,
    input  wire  nibexe_pkg::nibexe_ports_type ports_in,
    input  wire  nibexe_pkg::nibexe_addr_type low_pointer_pair,
    input  wire  nibexe_pkg::nibexe_addr_type high_pointer_pair,
    input  wire                           carry_flag,
    output nibexe_pkg::nibexe_nib_type    accumulator,
    output nibexe_pkg::nibexe_pc_type     program_counter
);
    import nibexe_pkg::*;

    nibexe_state_type state_r;
    logic [7:0]       op_r;
    logic [7:0]       op2_r;
    nibexe_nib_type   acc_r;
    nibexe_pc_type    pc_r;
    nibexe_addr_type  mem_addr_r;
    nibexe_nib_type   mem_data_r;
    nibexe_nib_type   acc_plus;
    nibexe_nib_type   mem_plus;
    logic             is_two_byte;
    logic             cond_jump;
    logic             cond_taken;

    // decoded first-byte fields
    logic [2:0]       pfx3;
    logic [3:0]       pfx4;
    logic [4:0]       pfx5;
    logic [1:0]       acc_bit_sel;
    logic             is_acc_bit;
    logic             is_carry;
    logic             is_no_carry;
    logic             is_direct;
    logic             is_mem_inc;

    ////////////////////////////////////////////////////////////////////////////
    // increment units, shared width, no carry path
    // trade: two small adders rather than one shared behind a mux
    nibexe_inc u_inc_acc (
        .value      (acc_r),
        .value_plus (acc_plus)
    );
    // memory adder works on the returned nibble so write data is registered
    nibexe_inc u_inc_mem (
        .value      (mem_rdata),
        .value_plus (mem_plus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // first-byte fields, split once so each class test reads by name
    always_comb begin
        pfx3        = op_r[`NIBEXE_F_PFX3];
        pfx4        = op_r[`NIBEXE_F_PFX4];
        pfx5        = op_r[`NIBEXE_F_PFX5];
        acc_bit_sel = op_r[`NIBEXE_F_BIT_SEL];
        is_acc_bit  = (pfx3 == `NIBEXE_PFX_ACC_BIT);
        is_carry    = (pfx5 == `NIBEXE_PFX_CARRY);
        is_no_carry = (pfx5 == `NIBEXE_PFX_NO_CARRY);
        is_direct   = (pfx4 == `NIBEXE_PFX_DIRECT);
        is_mem_inc  = (op_r == `NIBEXE_OP_INC_MEM_LOW) || (op_r == `NIBEXE_OP_INC_MEM_HIGH);
    end

    ////////////////////////////////////////////////////////////////////////////
    // opcode classes; the carry input is only read, never written
    always_comb begin
        is_two_byte = is_acc_bit || is_carry || is_no_carry || is_direct;
        cond_jump   = is_acc_bit || is_carry || is_no_carry;
        cond_taken  = 1'b0;
        if (is_acc_bit) begin
            cond_taken = acc_r[acc_bit_sel];
        end else if (is_carry) begin
            cond_taken = carry_flag;
        end else if (is_no_carry) begin
            cond_taken = !carry_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    // every path returns to FETCH, so no opcode can stall the core
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= NIBEXE_FETCH;
        end else begin
            unique case (state_r)
                NIBEXE_FETCH: begin
                    state_r <= NIBEXE_DECODE;
                end
                NIBEXE_DECODE: begin
                    if (is_two_byte) begin
                        state_r <= NIBEXE_FETCH2;
                    end else if (is_mem_inc) begin
                        state_r <= NIBEXE_MEM_RD;
                    end else begin
                        state_r <= NIBEXE_FETCH;
                    end
                end
                NIBEXE_FETCH2: state_r <= NIBEXE_JUMP;
                NIBEXE_JUMP:   state_r <= NIBEXE_FETCH;
                NIBEXE_MEM_RD: state_r <= NIBEXE_MEM_WR;
                NIBEXE_MEM_WR: state_r <= NIBEXE_FETCH;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction bytes, captured at the edge that ends the cycle their address is shown
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_r  <= `NIBEXE_OP_RESET;
            op2_r <= `NIBEXE_OP_RESET;
        end else if (state_r == NIBEXE_FETCH) begin
            op_r <= prog_data;
        end else if (state_r == NIBEXE_FETCH2) begin
            op2_r <= prog_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc_r <= `NIBEXE_PC_RESET;
        end else if (state_r == NIBEXE_DECODE && !is_two_byte) begin
            pc_r <= pc_r + `NIBEXE_PC_ONE;
        end else if (state_r == NIBEXE_JUMP) begin
            // untaken skip counts from the first byte, covering both bytes
            if (!cond_jump) begin
                pc_r <= {op_r[`NIBEXE_F_ADDR12], op2_r};
            end else if (cond_taken) begin
                // taken conditional jumps stay within the current 2K half
                pc_r <= {pc_r[`NIBEXE_PC_KEEP_BIT], op_r[`NIBEXE_F_ADDR11], op2_r};
            end else begin
                pc_r <= pc_r + `NIBEXE_PC_TWO;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accumulator; carry is an input here, so it is never written
    // unknown opcodes take the default and leave the accumulator alone
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc_r <= `NIBEXE_ACC_RESET;
        end else if (state_r == NIBEXE_DECODE) begin
            unique case (op_r)
                `NIBEXE_OP_PORT_FIRST:  acc_r <= ports_in.first;
                `NIBEXE_OP_PORT_SECOND: acc_r <= ports_in.second;
                `NIBEXE_OP_PORT_THIRD:  acc_r <= ports_in.third;
                `NIBEXE_OP_INC_ACC:     acc_r <= acc_plus;
                default:                acc_r <= acc_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory increment: latch pointer at decode, read, then write back
    // pointer captured early so a later pointer change cannot split the pair
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_addr_r <= `NIBEXE_ADDR_RESET;
        end else if (state_r == NIBEXE_DECODE) begin
            if (op_r == `NIBEXE_OP_INC_MEM_HIGH) begin
                mem_addr_r <= high_pointer_pair;
            end else begin
                mem_addr_r <= low_pointer_pair;
            end
        end
    end

    // incremented nibble registered at the end of the read cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_data_r <= `NIBEXE_NIB_RESET;
        end else if (state_r == NIBEXE_MEM_RD) begin
            mem_data_r <= mem_plus;
        end
    end

    // read strobe in MEM_RD, data back by MEM_WR's edge, write in MEM_WR
    always_comb begin
        mem_req.rd    = (state_r == NIBEXE_MEM_RD);
        mem_req.wr    = (state_r == NIBEXE_MEM_WR);
        mem_req.addr  = mem_addr_r;
        mem_req.wdata = mem_data_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // program memory address: second byte sits one past the first
    // limitation: the program store must answer before the next edge
    always_comb begin
        prog_addr = (state_r == NIBEXE_FETCH2) ? pc_r + `NIBEXE_PC_ONE : pc_r;
    end

    assign accumulator     = acc_r;
    assign program_counter = pc_r;
endmodule : nibexe_core

// ### core/nibexe_defs.svh
/*
 Constants for the nibble core increment and jump executor: opcodes,
 field positions, widths and reset values. Assumes inclusion by bare name.
*/
`ifndef NIBEXE_DEFS_SVH
`define NIBEXE_DEFS_SVH

`define NIBEXE_OP_PORT_FIRST   8'h32
`define NIBEXE_OP_PORT_SECOND  8'h33
`define NIBEXE_OP_PORT_THIRD   8'h34
`define NIBEXE_OP_INC_ACC      8'h31
`define NIBEXE_OP_INC_MEM_LOW  8'h0C
`define NIBEXE_OP_INC_MEM_HIGH 8'h0E
// upper bits of the first byte for the two-byte jumps
`define NIBEXE_PFX_ACC_BIT     3'h4
`define NIBEXE_PFX_CARRY       5'h18
`define NIBEXE_PFX_NO_CARRY    5'h19
`define NIBEXE_PFX_DIRECT      4'hE
`define NIBEXE_PC_RESET        12'h000
`define NIBEXE_ACC_RESET       4'h0
`define NIBEXE_ONE_NIB         4'h1
`define NIBEXE_PC_ONE          12'h001
`define NIBEXE_PC_TWO          12'h002
`define NIBEXE_PC_KEEP_BIT     11
`define NIBEXE_OP_RESET        8'h00
`define NIBEXE_ADDR_RESET      7'h00
`define NIBEXE_NIB_RESET       4'h0
// field positions within the first byte of a jump
`define NIBEXE_F_PFX3          7:5
`define NIBEXE_F_PFX4          7:4
`define NIBEXE_F_PFX5          7:3
`define NIBEXE_F_BIT_SEL       4:3
`define NIBEXE_F_ADDR11        2:0
`define NIBEXE_F_ADDR12        3:0

`endif

// ### core/nibexe_pkg.sv
/*
 Types shared by the executor and its increment unit.
 Assumes nibexe_defs.svh for the numeric constants.
*/
package nibexe_pkg;
    typedef logic [3:0]  nibexe_nib_type;
    typedef logic [11:0] nibexe_pc_type;
    typedef logic [6:0]  nibexe_addr_type;

    // data memory request toward the on-chip nibble store
    typedef struct packed {
        logic            rd;
        logic            wr;
        nibexe_addr_type addr;
        nibexe_nib_type  wdata;
    } nibexe_mem_req_type;

    // the three input ports sampled together
    typedef struct packed {
        nibexe_nib_type first;
        nibexe_nib_type second;
        nibexe_nib_type third;
    } nibexe_ports_type;

    typedef enum logic [2:0] {
        NIBEXE_FETCH,
        NIBEXE_DECODE,
        NIBEXE_FETCH2,
        NIBEXE_JUMP,
        NIBEXE_MEM_RD,
        NIBEXE_MEM_WR
    } nibexe_state_type;
endpackage : nibexe_pkg

// ### core/nibexe_inc.sv
/*
 Nibble incrementer used for the accumulator and memory increments.
 Assumes a purely combinational use; no carry output exists on purpose.
*/
`timescale 1ns/1ns
`include "nibexe_defs.svh"
module nibexe_inc (
    input  wire nibexe_pkg::nibexe_nib_type value,
    output wire nibexe_pkg::nibexe_nib_type value_plus
);
    import nibexe_pkg::*;
    // overflow is dropped so all-ones wraps to zero
    assign value_plus = value + `NIBEXE_ONE_NIB;
endmodule : nibexe_inc

// ### dv/nibexe_props.sv
/*
 checker for nibexe_core: memory strobe order and fetch relations.
 assumes it is bound onto nibexe_core and sees its ports only.
*/
`timescale 1ns/1ns
module nibexe_props (
    input wire logic                        core_clk,
    input wire logic                        rst,
    input wire logic [11:0]                 prog_addr,
    input wire nibexe_pkg::nibexe_mem_req_type mem_req,
    input wire nibexe_pkg::nibexe_nib_type  mem_rdata,
    input wire nibexe_pkg::nibexe_nib_type  accumulator,
    input wire nibexe_pkg::nibexe_pc_type   program_counter
);
    import nibexe_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // read then write, one cycle each, same nibble
    property p_rd_one; mem_req.rd |=> !mem_req.rd; endproperty
    a_rd_one: assert property (p_rd_one) else $error("read strobe too long");
    property p_wr_after_rd; mem_req.rd |=> mem_req.wr; endproperty
    a_wr_after_rd: assert property (p_wr_after_rd) else $error("no write back");
    property p_wr_cause; mem_req.wr |-> $past(mem_req.rd); endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("write without read");
    property p_addr_hold; mem_req.rd |=> $stable(mem_req.addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    // wrap comes from the 4-bit cast, carry out is dropped
    property p_wdata;
        mem_req.rd |=> mem_req.wdata == nibexe_nib_type'($past(mem_rdata) + 4'h1);
    endproperty
    a_wdata: assert property (p_wdata) else $error("bad write data");
    property p_acc_hold; mem_req.rd |-> ##1 $stable(accumulator) ##1 $stable(accumulator);
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved");
    ////////////////////////////////////////////////////////////////////////////////
    // second byte fetch shows pc+1 while pc holds
    property p_fetch2; prog_addr != program_counter |-> prog_addr == program_counter + 12'h001;
    endproperty
    a_fetch2: assert property (p_fetch2) else $error("second byte address");
    property p_fetch2_pc; prog_addr != program_counter |-> $stable(program_counter); endproperty
    a_fetch2_pc: assert property (p_fetch2_pc) else $error("pc moved early");
    c_wr: cover property (mem_req.wr);
    c_fetch2: cover property (prog_addr != program_counter);
    c_high: cover property ($rose(program_counter[11]));
endmodule : nibexe_props

bind nibexe_core nibexe_props nibexe_props_i (.core_clk, .rst, .prog_addr, .mem_req,
    .mem_rdata, .accumulator, .program_counter);

// ### dv/nibexe_mem_model.sv
/*
 program and data memory model with combinational reads.
 assumes the bench loads contents by hierarchy after time zero.
*/
`timescale 1ns/1ns
module nibexe_mem_model (
    input wire logic                        core_clk,
    input wire logic [11:0]                 prog_addr,
    output logic [7:0]                      prog_data,
    input wire nibexe_pkg::nibexe_mem_req_type mem_req,
    output nibexe_pkg::nibexe_nib_type      mem_rdata
);
    import nibexe_pkg::*;
    logic [7:0]     rom [4096];
    nibexe_nib_type ram [128];
    initial begin
        foreach (rom[i]) rom[i] = 8'h00;
        foreach (ram[i]) ram[i] = 4'h0;
    end
    // no stale data outside a read: the inverse shows instead
    assign prog_data = rom[prog_addr];
    assign mem_rdata = mem_req.rd ? ram[mem_req.addr] : ~ram[mem_req.addr];
    always @(posedge core_clk) begin
        if (mem_req.wr) begin
            ram[mem_req.addr] <= mem_req.wdata;
        end
    end
endmodule : nibexe_mem_model

// ### dv/nibble_cpu_inc_jump_exec_tb.sv
/*
 self-checking bench for nibexe_core running one fixed program.
 assumes nibexe_pkg, nibexe_core and the memory model compiled first.
*/
`timescale 1ns/1ns
module nibble_cpu_inc_jump_exec_tb;
    import nibexe_pkg::*;
    logic               core_clk;
    logic               rst;
    logic               carry_flag;
    logic [11:0]        prog_addr;
    logic [7:0]         prog_data;
    nibexe_mem_req_type mem_req;
    nibexe_nib_type     mem_rdata;
    nibexe_nib_type     accumulator;
    nibexe_ports_type   ports_in;
    nibexe_addr_type    low_pointer_pair;
    nibexe_addr_type    high_pointer_pair;
    nibexe_pc_type      program_counter;
    int                 bad_count;
    int                 compares;
    nibexe_core nibexe_core_i (.core_clk, .rst, .prog_addr, .prog_data, .mem_req, .mem_rdata,
        .ports_in, .low_pointer_pair, .high_pointer_pair, .carry_flag, .accumulator,
        .program_counter);
    nibexe_mem_model nibexe_mem_model_i (.core_clk, .prog_addr, .prog_data, .mem_req,
        .mem_rdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // bounded wait, sampled at the falling edge
    task automatic wait_pc(input logic [11:0] t);
        for (int i = 0; i < 60 && program_counter !== t; i++) @(negedge core_clk);
        check(program_counter, t);
    endtask : wait_pc
    task automatic prog(input logic [11:0] a, input logic [7:0] b[]);
        for (int i = 0; i < b.size(); i++) nibexe_mem_model_i.rom[a + 12'(i)] = b[i];
    endtask : prog
    task automatic complete_run;
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_port_read;
        wait_pc(12'h001);
        check(12'(accumulator), 12'h00A);
        wait_pc(12'h002);
        check(12'(accumulator), 12'h005);
        wait_pc(12'h003);
        check(12'(accumulator), 12'h00C);
    endtask : t_port_read
    task automatic t_inc_acc;
        wait_pc(12'h006);
        check(12'(accumulator), 12'h00F);
        wait_pc(12'h007);
        check(12'(accumulator), 12'h000);
    endtask : t_inc_acc
    task automatic t_mem_inc;
        wait_pc(12'h00B);
        check(12'(nibexe_mem_model_i.ram[5]), 12'h000);
        check(12'(nibexe_mem_model_i.ram[64]), 12'h004);
    endtask : t_mem_inc
    task automatic t_jumps;
        wait_pc(12'h020);
        wait_pc(12'h022);
        wait_pc(12'h030);
        carry_flag = 1'b1;
        wait_pc(12'h800);
        wait_pc(12'h810);
        wait_pc(12'h812);
        wait_pc(12'h814);
        // two increments set accumulator bits 0 and 1 for the middle bit selects
        wait_pc(12'h816);
        check(12'(accumulator), 12'h003);
        wait_pc(12'h840);
        wait_pc(12'h842);
    endtask : t_jumps
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        bad_count++;
        complete_run;
    end
    // inputs change on the falling edge, program loaded after model clears
    initial begin
        rst = 1'b1;
        carry_flag = 1'b0;
        ports_in = '{first: 4'hA, second: 4'h5, third: 4'hC};
        low_pointer_pair = 7'h05;
        high_pointer_pair = 7'h40;
        #1;
        prog(12'h000, '{8'h32, 8'h33, 8'h34, 8'h31, 8'h31, 8'h31, 8'h31, 8'h0C, 8'h0E,
            8'h81, 8'h00, 8'h31, 8'h80, 8'h20});
        prog(12'h020, '{8'hC7, 8'hFF, 8'hC8, 8'h30});
        prog(12'h030, '{8'hE8, 8'h00});
        prog(12'h800, '{8'hC0, 8'h10});
        prog(12'h810, '{8'hC8, 8'h00, 8'h98, 8'h00, 8'h31, 8'h31, 8'h88, 8'h40});
        prog(12'h840, '{8'h90, 8'h00});
        nibexe_mem_model_i.ram[5] = 4'hF;
        nibexe_mem_model_i.ram[64] = 4'h3;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_port_read;
        t_inc_acc;
        t_mem_inc;
        t_jumps;
        complete_run;
    end
endmodule : nibble_cpu_inc_jump_exec_tb
